/* File: dv/mps_asserts.sv */
// Concurrent checks on the stream links between source and synthesiser
`timescale 1ns/1ps
`default_nettype none

module mps_asserts
  import mps_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  // Input streams
  input wire logic              cfg_tvalid,
  input wire logic              cfg_tready,
  input wire logic              cfg_tlast,
  input wire logic              ph_tvalid,
  input wire logic              ph_tready,
  input wire logic              ph_tlast,
  input wire logic [CH_W-1:0]   ph_tuser,
  // Output streams
  input wire logic              data_tvalid,
  input wire logic              data_tready,
  input wire logic [DATA_W-1:0] data_tdata,
  input wire logic [CH_W-1:0]   data_tuser,
  input wire logic              data_tlast,
  input wire logic              phs_tvalid,
  input wire logic              phs_tready,
  input wire logic [CH_W-1:0]   phs_tuser,
  // Events
  input wire logic              ev_ph_last_missing,
  input wire logic              ev_ph_last_unexpected,
  input wire logic              ev_ph_chan_wrong,
  input wire logic              ev_cfg_last_missing,
  input wire logic              ev_cfg_last_unexpected
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////
  // Expected channel counters
  logic [CH_W-1:0] cfg_ch;
  logic [CH_W-1:0] ph_ch;
  logic [CH_W-1:0] out_ch;
  wire logic       cfg_take = cfg_tvalid && cfg_tready;
  wire logic       ph_take  = ph_tvalid && ph_tready;
  wire logic       out_take = data_tvalid && data_tready;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_ch <= CH_FIRST;
      ph_ch  <= CH_FIRST;
      out_ch <= CH_FIRST;
    end else begin
      cfg_ch <= cfg_take ? cfg_ch + 2'h1 : cfg_ch;
      ph_ch  <= ph_take ? ph_ch + 2'h1 : ph_ch;
      out_ch <= out_take ? out_ch + 2'h1 : out_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Properties
  property p_latency;
    ph_take ##1 data_tready && phs_tready |=>
      data_tvalid && phs_tvalid && data_tuser == $past(ph_tuser, LATENCY);
  endproperty
  a_latency: assert property (p_latency)
    else $error("result not presented two cycles after phase input");

  property p_order;
    data_tvalid |-> data_tuser == out_ch && phs_tuser == out_ch &&
      data_tlast == (out_ch == CH_LAST);
  endproperty
  a_order: assert property (p_order)
    else $error("output channel out of round-robin order");

  property p_hold;
    data_tvalid && !data_tready |=> data_tvalid && $stable(data_tdata) && $stable(data_tuser);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed while waiting for ready");

  property p_stall;
    (data_tvalid && !data_tready) || (phs_tvalid && !phs_tready) |-> !ph_tready;
  endproperty
  a_stall: assert property (p_stall)
    else $error("phase input accepted while output stalled");

  property p_sext;
    data_tvalid |-> data_tdata[31:26] == {6{data_tdata[26]}} &&
      data_tdata[15:10] == {6{data_tdata[10]}};
  endproperty
  a_sext: assert property (p_sext)
    else $error("sine or cosine field not sign extended");

  property p_reset;
    $rose(rstn) |-> !cfg_tready && !data_tvalid && !phs_tvalid ##1 cfg_tready;
  endproperty
  a_reset: assert property (p_reset)
    else $error("wrong stream state after reset release");

  property p_ph_miss;
    ev_ph_last_missing == (ph_take && ph_ch == CH_LAST && !ph_tlast);
  endproperty
  a_ph_miss: assert property (p_ph_miss)
    else $error("phase missing-last event wrong");

  property p_ph_unexp;
    ev_ph_last_unexpected == (ph_take && ph_tlast && ph_ch != CH_LAST);
  endproperty
  a_ph_unexp: assert property (p_ph_unexp)
    else $error("phase unexpected-last event wrong");

  property p_chan;
    ev_ph_chan_wrong == (ph_take && ph_tuser != ph_ch);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel mismatch event wrong");

  property p_cfg_miss;
    ev_cfg_last_missing == (cfg_take && cfg_ch == CH_LAST && !cfg_tlast);
  endproperty
  a_cfg_miss: assert property (p_cfg_miss)
    else $error("config missing-last event wrong");

  property p_cfg_unexp;
    ev_cfg_last_unexpected == (cfg_take && cfg_tlast && cfg_ch != CH_LAST);
  endproperty
  a_cfg_unexp: assert property (p_cfg_unexp)
    else $error("config unexpected-last event wrong");
endmodule

`default_nettype wire

/* File: dv/mps_tb.sv */
// Self-checking bench for the phase synthesiser and its stream source
`timescale 1ns/1ps
`default_nettype none

module mps_tb
  import mps_pkg::*;
;
  localparam logic [PH_W-1:0] MOD = 16'h0003;
  // Fault beats: stream, last, user, expected events
  localparam logic [8:0] FAULTS [10] = '{9'h000, 9'h000, 9'h000, 9'h002, 9'h081,
                                         9'h100, 9'h144, 9'h140, 9'h170, 9'h188};
  logic                  clock;
  logic                  rstn;
  logic                  u_cfg_valid;
  logic                  u_ph_valid;
  logic                  u_out_ready;
  logic [PH_W-1:0]       u_cfg_step;
  logic [PH_W-1:0]       u_cfg_shift;
  logic [PH_W-1:0]       u_ph_mod;
  wire logic             u_cfg_ready;
  wire logic             u_ph_ready;
  wire logic             u_out_valid;
  wire logic [DATA_W-1:0] u_out_data;
  wire logic [PHS_W-1:0] u_out_phase;
  wire logic [CH_W-1:0]  u_out_ch;
  int                    num_errors;
  int                    checks_done;
  int                    sent;
  int                    rcvd;
  logic [PH_W-1:0]       step_m [CHANNELS];
  logic [PH_W-1:0]       shift_m [CHANNELS];
  logic [PH_W-1:0]       acc_m [CHANNELS];
  logic [PH_W-1:0]       exp_ph;
  logic [PH_W-1:0]       exp_q;
  logic [CH_W-1:0]       exp_ch;

  mps_if bus ();
  mps_if f_bus ();
  mps_device i_mps_device (.clock(clock), .rstn(rstn), .bus(bus));
  mps_device i_mps_device_f (.clock(clock), .rstn(rstn), .bus(f_bus));
  mps_source i_mps_source (.clock(clock), .rstn(rstn), .bus(bus),
    .u_cfg_valid(u_cfg_valid), .u_cfg_step(u_cfg_step), .u_cfg_shift(u_cfg_shift),
    .u_cfg_ready(u_cfg_ready), .u_ph_valid(u_ph_valid), .u_ph_mod(u_ph_mod),
    .u_ph_ready(u_ph_ready), .u_out_ready(u_out_ready), .u_out_valid(u_out_valid),
    .u_out_data(u_out_data), .u_out_phase(u_out_phase), .u_out_ch(u_out_ch));
  mps_asserts i_mps_asserts (.clock(clock), .rstn(rstn), .cfg_tvalid(bus.cfg_tvalid),
    .cfg_tready(bus.cfg_tready), .cfg_tlast(bus.cfg_tlast), .ph_tvalid(bus.ph_tvalid),
    .ph_tready(bus.ph_tready), .ph_tlast(bus.ph_tlast), .ph_tuser(bus.ph_tuser),
    .data_tvalid(bus.data_tvalid), .data_tready(bus.data_tready),
    .data_tdata(bus.data_tdata), .data_tuser(bus.data_tuser), .data_tlast(bus.data_tlast),
    .phs_tvalid(bus.phs_tvalid), .phs_tready(bus.phs_tready), .phs_tuser(bus.phs_tuser),
    .ev_ph_last_missing(bus.ev_ph_last_missing),
    .ev_ph_last_unexpected(bus.ev_ph_last_unexpected),
    .ev_ph_chan_wrong(bus.ev_ph_chan_wrong), .ev_cfg_last_missing(bus.ev_cfg_last_missing),
    .ev_cfg_last_unexpected(bus.ev_cfg_last_unexpected));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic give_up();
    num_errors++;
    $display("mismatch wait expected done seen timeout");
    test_done();
  endtask

  //////////////////////////////////////////////////////////////////////
  // Stimulus, all changes at the falling edge
  task automatic do_reset();
    rstn = 1'b0;
    exp_ch = CH_FIRST;
    for (int c = 0; c < CHANNELS; c++) begin
      step_m[c] = '0;
      shift_m[c] = '0;
      acc_m[c] = '0;
    end
    repeat (RESET_MIN_CYCLES + 1) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  task automatic wait_hi(input bit is_ph);
    int t;
    t = 0;
    #1;
    while ((is_ph ? u_ph_ready : u_cfg_ready) !== 1'b1) begin
      @(negedge clock);
      #1;
      t++;
      if (t > 200) give_up();
    end
  endtask

  task automatic cfg_vec(input logic [4*PH_W-1:0] st, input logic [4*PH_W-1:0] sh);
    u_cfg_valid = 1'b1;
    for (int c = 0; c < CHANNELS; c++) begin
      u_cfg_step = st[c*PH_W +: PH_W];
      u_cfg_shift = sh[c*PH_W +: PH_W];
      step_m[c] = u_cfg_step;
      shift_m[c] = u_cfg_shift;
      wait_hi(1'b0);
      @(negedge clock);
    end
    u_cfg_valid = 1'b0;
  endtask

  task automatic ph_run(input int n);
    u_ph_valid = 1'b1;
    repeat (n) begin
      wait_hi(1'b1);
      @(negedge clock);
      sent++;
    end
    u_ph_valid = 1'b0;
  endtask

  task automatic drain(input string name);
    int t;
    t = 0;
    while (rcvd != sent) begin
      @(negedge clock);
      t++;
      if (t > 200) give_up();
    end
    $display("test %s done", name);
  endtask

  task automatic fault_beat(input logic [8:0] b);
    f_bus.ph_tvalid = b[8];
    f_bus.cfg_tvalid = !b[8];
    f_bus.ph_tlast = b[7];
    f_bus.cfg_tlast = b[7];
    f_bus.ph_tuser = b[6:5];
    #1;
    check("events", {f_bus.ev_ph_last_missing, f_bus.ev_ph_last_unexpected,
      f_bus.ev_ph_chan_wrong, f_bus.ev_cfg_last_missing,
      f_bus.ev_cfg_last_unexpected}, b[4:0]);
    @(negedge clock);
  endtask

  // Result monitor with running phase model, sampled while outputs are settled
  always @(negedge clock) begin
    if (rstn && u_out_valid === 1'b1) begin
      acc_m[exp_ch] = acc_m[exp_ch] + step_m[exp_ch] + MOD;
      exp_ph = acc_m[exp_ch] + shift_m[exp_ch];
      exp_q = exp_ph + QUARTER_TURN;
      check("channel", u_out_ch, exp_ch);
      check("phase", u_out_phase, exp_ph);
      check("sine sign", u_out_data[31:26], {6{exp_ph[15]}});
      check("cosine sign", u_out_data[15:10], {6{exp_q[15]}});
      exp_ch = exp_ch + 2'h1;
      rcvd++;
    end
  end

  initial begin
    {u_cfg_valid, u_ph_valid, u_cfg_step, u_cfg_shift} = '0;
    u_ph_mod = MOD;
    u_out_ready = 1'b1;
    {f_bus.cfg_tvalid, f_bus.cfg_tdata, f_bus.cfg_tlast} = '0;
    {f_bus.ph_tvalid, f_bus.ph_tdata, f_bus.ph_tlast, f_bus.ph_tuser} = '0;
    f_bus.data_tready = 1'b1;
    f_bus.phs_tready = 1'b1;
    {num_errors, checks_done, sent, rcvd} = '0;
    do_reset();
    cfg_vec({16'h7FFF, 16'h0001, 16'hC000, 16'h1000},
            {16'h4000, 16'hFFFF, 16'h0100, 16'h0000});
    ph_run(12);
    drain("stream");
    u_out_ready = 1'b0;
    fork
      ph_run(8);
      begin
        repeat (6) @(negedge clock);
        u_out_ready = 1'b1;
      end
    join
    drain("backpressure");
    cfg_vec({16'h0010, 16'hFFF0, 16'h8000, 16'h0123},
            {16'h0000, 16'h8000, 16'h00FF, 16'h1111});
    ph_run(8);
    drain("reconfig");
    do_reset();
    ph_run(4);
    drain("reset");
    foreach (FAULTS[i]) fault_beat(FAULTS[i]);
    f_bus.ph_tvalid = 1'b0;
    f_bus.cfg_tvalid = 1'b0;
    $display("test events done");
    test_done();
  end
endmodule

`default_nettype wire

/* File: verilog/mps_device.sv */
// Time-multiplexed phase accumulator and sine/cosine source with stream ports
//
// Contract
// - Channels output round-robin, channel 0 first.
// - Phase input latency is a fixed minimum.
// - Config latency counts from reset release.
// - Config changes wait for channel-counter alignment.
// - Reset held low at least two cycles.
// - With back-pressure, latency only has a minimum.
// - Without back-pressure, latency is constant.
// - Phase is running step sum plus shift.
// - Every stream carries a valid handshake.
// - Config has no address; last marks final channel.
// - One config transfer carries step and shift.
// - Flag missing last on final phase transfer.
// - Flag phase last at wrong position.
// - Flag phase channel id mismatch.
// - Flag missing last on final config transfer.
// - Flag config last at wrong position.
// - Channel id carried in output user sideband.
// - Sine and cosine share one data payload.
// - Phase stream carries accumulated phase, two bytes wide.
// - Events combinational, same cycle, each cycle.
// - Sign-extend sin/cos per byte, cosine low.
// - Sign-extend phase field to eight-bit multiple.
`timescale 1ns/1ps
`default_nettype none

module mps_device
  import mps_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Stream links
  mps_if.dev        bus
);

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-wave sine table, amplitude in OUT_W-bit signed range
  function automatic logic [OUT_W-2:0] mps_quarter(input logic [3:0] idx);
    case (idx)
      4'h0:    mps_quarter = 10'h032;
      4'h1:    mps_quarter = 10'h096;
      4'h2:    mps_quarter = 10'h0F9;
      4'h3:    mps_quarter = 10'h159;
      4'h4:    mps_quarter = 10'h1B5;
      4'h5:    mps_quarter = 10'h20E;
      4'h6:    mps_quarter = 10'h261;
      4'h7:    mps_quarter = 10'h2AF;
      4'h8:    mps_quarter = 10'h2F6;
      4'h9:    mps_quarter = 10'h336;
      4'hA:    mps_quarter = 10'h36D;
      4'hB:    mps_quarter = 10'h39D;
      4'hC:    mps_quarter = 10'h3C3;
      4'hD:    mps_quarter = 10'h3E0;
      4'hE:    mps_quarter = 10'h3F4;
      default: mps_quarter = 10'h3FE;
    endcase
  endfunction

  // Signed sine of a phase, sign-extended to one byte-aligned field
  function automatic logic [OUT_FLD_W-1:0] mps_sine(input logic [PH_W-1:0] ph);
    logic [OUT_W-2:0] mag;
    logic [OUT_W-1:0] val;
    mag = mps_quarter(ph[PH_W-2] ? ~ph[PH_W-3:PH_W-6] : ph[PH_W-3:PH_W-6]);
    val = ph[PH_W-1] ? (~{1'b0, mag} + 11'h001) : {1'b0, mag};
    mps_sine = {{(OUT_FLD_W-OUT_W){val[OUT_W-1]}}, val};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [CH_W-1:0]      cfg_ch;
  logic [CH_W-1:0]      ph_ch;
  logic                 pend_full;
  logic                 cfg_rdy;
  logic [PH_W-1:0]      acc        [CHANNELS];
  logic [PH_W-1:0]      step_act   [CHANNELS];
  logic [PH_W-1:0]      shift_act  [CHANNELS];
  logic [PH_W-1:0]      step_pend  [CHANNELS];
  logic [PH_W-1:0]      shift_pend [CHANNELS];
  logic                 s1_valid;
  logic [PH_W-1:0]      s1_phase;
  logic [CH_W-1:0]      s1_ch;
  logic                 s1_last;
  logic                 d_valid;
  logic                 p_valid;
  logic [DATA_W-1:0]    d_data;
  logic [PHS_W-1:0]     p_data;
  logic [CH_W-1:0]      o_ch;
  logic                 o_last;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake decode
  wire                  stall;
  wire                  advance;
  wire                  cfg_fire;
  wire                  ph_fire;
  wire                  cfg_last_exp;
  wire                  ph_last_exp;
  wire                  apply;
  wire [PH_W-1:0]       cur_step;
  wire [PH_W-1:0]       cur_shift;
  wire [PH_W-1:0]       next_acc;

  assign stall        = (d_valid & ~bus.data_tready) | (p_valid & ~bus.phs_tready);
  assign advance      = ~stall;
  assign cfg_fire     = bus.cfg_tvalid & cfg_rdy;
  assign ph_fire      = bus.ph_tvalid & advance;
  assign cfg_last_exp = (cfg_ch == CH_LAST);
  assign ph_last_exp  = (ph_ch == CH_LAST);
  assign apply        = pend_full & ph_fire & (ph_ch == CH_FIRST);
  assign cur_step     = apply ? step_pend[ph_ch] : step_act[ph_ch];
  assign cur_shift    = apply ? shift_pend[ph_ch] : shift_act[ph_ch];
  assign next_acc     = acc[ph_ch] + cur_step + bus.ph_tdata;

  assign bus.cfg_tready = cfg_rdy;
  assign bus.ph_tready  = advance;

  ////////////////////////////////////////////////////////////////////////////
  // Events, same cycle as the offending transfer
  assign bus.ev_cfg_last_missing    = cfg_fire & cfg_last_exp & ~bus.cfg_tlast;
  assign bus.ev_cfg_last_unexpected = cfg_fire & ~cfg_last_exp & bus.cfg_tlast;
  assign bus.ev_ph_last_missing     = ph_fire & ph_last_exp & ~bus.ph_tlast;
  assign bus.ev_ph_last_unexpected  = ph_fire & ~ph_last_exp & bus.ph_tlast;
  assign bus.ev_ph_chan_wrong       = ph_fire & (bus.ph_tuser != ph_ch);

  ////////////////////////////////////////////////////////////////////////////
  // Config capture: channel from internal count, step and shift together
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_ch    <= CH_FIRST;
      pend_full <= 1'b0;
      cfg_rdy   <= 1'b0;
    end else begin
      cfg_rdy <= 1'b1;
      if (cfg_fire) begin
        cfg_ch <= (bus.cfg_tlast | cfg_last_exp) ? CH_FIRST : mps_next_ch(cfg_ch);
      end
      // Completion wins over the clear by apply
      if (cfg_fire & cfg_last_exp) begin
        pend_full <= 1'b1;
      end else if (apply) begin
        pend_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        step_pend[i]  <= PH_RESET;
        shift_pend[i] <= PH_RESET;
      end
    end else if (cfg_fire) begin
      step_pend[cfg_ch]  <= bus.cfg_tdata[CFG_STEP_LSB +: PH_W];
      shift_pend[cfg_ch] <= bus.cfg_tdata[CFG_SHIFT_LSB +: PH_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulate per channel, new settings only at a vector boundary
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph_ch <= CH_FIRST;
      for (int i = 0; i < CHANNELS; i++) begin
        acc[i]       <= PH_RESET;
        step_act[i]  <= PH_RESET;
        shift_act[i] <= PH_RESET;
      end
    end else if (ph_fire) begin
      ph_ch      <= mps_next_ch(ph_ch);
      acc[ph_ch] <= next_acc;
      if (apply) begin
        for (int i = 0; i < CHANNELS; i++) begin
          step_act[i]  <= step_pend[i];
          shift_act[i] <= shift_pend[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline: stage 1 phase, stage 2 lookup and output registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_valid <= 1'b0;
      s1_phase <= PH_RESET;
      s1_ch    <= CH_FIRST;
      s1_last  <= 1'b0;
    end else if (advance) begin
      s1_valid <= ph_fire;
      s1_phase <= next_acc + cur_shift;
      s1_ch    <= ph_ch;
      s1_last  <= ph_last_exp;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      d_valid <= 1'b0;
      p_valid <= 1'b0;
      d_data  <= '0;
      p_data  <= '0;
      o_ch    <= CH_FIRST;
      o_last  <= 1'b0;
    end else if (advance) begin
      d_valid <= s1_valid;
      p_valid <= s1_valid;
      d_data  <= {mps_sine(s1_phase), mps_sine(s1_phase + QUARTER_TURN)};
      p_data  <= {{(PHS_W-PH_W){s1_phase[PH_W-1]}}, s1_phase};
      o_ch    <= s1_ch;
      o_last  <= s1_last;
    end else begin
      d_valid <= d_valid & ~bus.data_tready;
      p_valid <= p_valid & ~bus.phs_tready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output streams
  assign bus.data_tvalid = d_valid;
  assign bus.data_tdata  = d_data;
  assign bus.data_tuser  = o_ch;
  assign bus.data_tlast  = o_last;
  assign bus.phs_tvalid  = p_valid;
  assign bus.phs_tdata   = p_data;
  assign bus.phs_tuser   = o_ch;
  assign bus.phs_tlast   = o_last;

endmodule

`default_nettype wire

/* File: verilog/mps_if.sv */
// Stream links between the phase synthesiser and its upstream/downstream logic
`timescale 1ns/1ps
`default_nettype none

interface mps_if;
  import mps_pkg::*;

  // Configuration stream
  logic                cfg_tvalid;
  logic                cfg_tready;
  logic [CFG_W-1:0]    cfg_tdata;
  logic                cfg_tlast;
  // Phase input stream
  logic                ph_tvalid;
  logic                ph_tready;
  logic [PH_W-1:0]     ph_tdata;
  logic                ph_tlast;
  logic [CH_W-1:0]     ph_tuser;
  // Output data stream
  logic                data_tvalid;
  logic                data_tready;
  logic [DATA_W-1:0]   data_tdata;
  logic [CH_W-1:0]     data_tuser;
  logic                data_tlast;
  // Output phase stream
  logic                phs_tvalid;
  logic                phs_tready;
  logic [PHS_W-1:0]    phs_tdata;
  logic [CH_W-1:0]     phs_tuser;
  logic                phs_tlast;
  // Events
  logic                ev_ph_last_missing;
  logic                ev_ph_last_unexpected;
  logic                ev_ph_chan_wrong;
  logic                ev_cfg_last_missing;
  logic                ev_cfg_last_unexpected;

  modport dev (
    input  cfg_tvalid, cfg_tdata, cfg_tlast,
    output cfg_tready,
    input  ph_tvalid, ph_tdata, ph_tlast, ph_tuser,
    output ph_tready,
    output data_tvalid, data_tdata, data_tuser, data_tlast,
    input  data_tready,
    output phs_tvalid, phs_tdata, phs_tuser, phs_tlast,
    input  phs_tready,
    output ev_ph_last_missing, ev_ph_last_unexpected, ev_ph_chan_wrong,
    output ev_cfg_last_missing, ev_cfg_last_unexpected
  );

  modport src (
    output cfg_tvalid, cfg_tdata, cfg_tlast,
    input  cfg_tready,
    output ph_tvalid, ph_tdata, ph_tlast, ph_tuser,
    input  ph_tready,
    input  data_tvalid, data_tdata, data_tuser, data_tlast,
    output data_tready,
    input  phs_tvalid, phs_tdata, phs_tuser, phs_tlast,
    output phs_tready,
    input  ev_ph_last_missing, ev_ph_last_unexpected, ev_ph_chan_wrong,
    input  ev_cfg_last_missing, ev_cfg_last_unexpected
  );
endinterface

`default_nettype wire

/* File: verilog/mps_pkg.sv */
// Shared constants and helpers for the multichannel phase synthesiser
`default_nettype none

package mps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int CHANNELS  = 4;
  localparam int CH_W      = 2;
  localparam int PH_W      = 16;
  localparam int OUT_W     = 11;
  localparam int OUT_FLD_W = 16;
  localparam int DATA_W    = 2 * OUT_FLD_W;
  localparam int PHS_W     = 16;
  localparam int CFG_W     = 2 * PH_W;

  ////////////////////////////////////////////////////////////////////////////
  // Positions, counts and reset values
  localparam int                 CFG_STEP_LSB     = 0;
  localparam int                 CFG_SHIFT_LSB    = PH_W;
  localparam int                 DATA_COS_LSB     = 0;
  localparam int                 DATA_SIN_LSB     = OUT_FLD_W;
  localparam int                 LATENCY          = 2;
  localparam int                 RESET_MIN_CYCLES = 2;
  localparam logic [CH_W-1:0]    CH_FIRST         = 2'h0;
  localparam logic [CH_W-1:0]    CH_LAST          = 2'h3;
  localparam logic [PH_W-1:0]    PH_RESET         = 16'h0000;
  localparam logic [PH_W-1:0]    QUARTER_TURN     = 16'h4000;

  ////////////////////////////////////////////////////////////////////////////
  // Channel counter step with wrap
  function automatic logic [CH_W-1:0] mps_next_ch(input logic [CH_W-1:0] ch);
    mps_next_ch = (ch == CH_LAST) ? CH_FIRST : ch + 2'h1;
  endfunction

endpackage

`default_nettype wire

/* File: verilog/mps_source.sv */
// Upstream and downstream logic that feeds and drains the phase synthesiser
`timescale 1ns/1ps
`default_nettype none

module mps_source
  import mps_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Stream links
  mps_if.src                     bus,
  // Configuration request
  input  wire logic              u_cfg_valid,
  input  wire logic [PH_W-1:0]   u_cfg_step,
  input  wire logic [PH_W-1:0]   u_cfg_shift,
  output logic                   u_cfg_ready,
  // Phase modulation request
  input  wire logic              u_ph_valid,
  input  wire logic [PH_W-1:0]   u_ph_mod,
  output logic                   u_ph_ready,
  // Result sink
  input  wire logic              u_out_ready,
  output logic                   u_out_valid,
  output logic [DATA_W-1:0]      u_out_data,
  output logic [PHS_W-1:0]       u_out_phase,
  output logic [CH_W-1:0]        u_out_ch
);

  logic                cfg_v;
  logic [CFG_W-1:0]    cfg_d;
  logic                cfg_l;
  logic [CH_W-1:0]     cfg_ch;
  logic                ph_v;
  logic [PH_W-1:0]     ph_d;
  logic [CH_W-1:0]     ph_ch;
  logic                out_rdy;

  wire                 cfg_load;
  wire                 ph_load;
  wire                 got_data;

  assign cfg_load    = u_cfg_valid & (~cfg_v | bus.cfg_tready);
  assign ph_load     = u_ph_valid & (~ph_v | bus.ph_tready);
  assign got_data    = bus.data_tvalid & out_rdy;
  assign u_cfg_ready = ~cfg_v | bus.cfg_tready;
  assign u_ph_ready  = ~ph_v | bus.ph_tready;

  ////////////////////////////////////////////////////////////////////////////
  // Config stream, last flag on final channel
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_v  <= 1'b0;
      cfg_d  <= '0;
      cfg_l  <= 1'b0;
      cfg_ch <= CH_FIRST;
    end else if (cfg_load) begin
      cfg_v  <= 1'b1;
      cfg_d  <= {u_cfg_shift, u_cfg_step};
      cfg_l  <= (cfg_ch == CH_LAST);
      cfg_ch <= mps_next_ch(cfg_ch);
    end else if (bus.cfg_tready) begin
      cfg_v <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase stream with channel id and vector last
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph_v  <= 1'b0;
      ph_d  <= PH_RESET;
      ph_ch <= CH_FIRST;
    end else if (ph_load) begin
      ph_v  <= 1'b1;
      ph_d  <= u_ph_mod;
      ph_ch <= (ph_v & ~bus.ph_tready) ? ph_ch : (ph_v ? mps_next_ch(ph_ch) : ph_ch);
    end else if (bus.ph_tready) begin
      ph_v  <= 1'b0;
      ph_ch <= ph_v ? mps_next_ch(ph_ch) : ph_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_rdy     <= 1'b0;
      u_out_valid <= 1'b0;
      u_out_data  <= '0;
      u_out_phase <= '0;
      u_out_ch    <= CH_FIRST;
    end else begin
      out_rdy     <= u_out_ready;
      u_out_valid <= got_data;
      if (got_data) begin
        u_out_data  <= bus.data_tdata;
        u_out_phase <= bus.phs_tdata;
        u_out_ch    <= bus.data_tuser;
      end
    end
  end

  assign bus.cfg_tvalid  = cfg_v;
  assign bus.cfg_tdata   = cfg_d;
  assign bus.cfg_tlast   = cfg_l;
  assign bus.ph_tvalid   = ph_v;
  assign bus.ph_tdata    = ph_d;
  assign bus.ph_tlast    = (ph_ch == CH_LAST);
  assign bus.ph_tuser    = ph_ch;
  assign bus.data_tready = out_rdy;
  assign bus.phs_tready  = out_rdy;

endmodule

`default_nettype wire
